// >>> vem_defines.svh
// Offsets, field positions, reset values and coding constants of the mode/VBI register bank.
// Assumes inclusion by bare name from the design modules vem_id_crc and vem_mode_vbi_regs.
`ifndef VEM_DEFINES_SVH
`define VEM_DEFINES_SVH

`define VEM_ADDR_MODE 5'h00
`define VEM_ADDR_LOW 5'h01
`define VEM_ADDR_HIGH 5'h02
`define VEM_RST_MODE 8'h00
`define VEM_RST_LOW 8'h00
`define VEM_RST_HIGH 6'h00

`define VEM_MODE_STD 0
`define VEM_MODE_SUBRST 1
`define VEM_MODE_VID 2
`define VEM_MODE_WIDE 3
`define VEM_MODE_MAS 4
`define VEM_MODE_BARS 5
`define VEM_MODE_BLACK 6
`define VEM_MODE_DAC 7

`define VEM_ADDR_RD_BIT 5
`define VEM_LAST_BIT 3'h7
`define VEM_PIN_RST 3'h6 // Idle pins: select high, clock high, so no false edge

`define VEM_CRC_POLY 6'h03
`define VEM_CRC_PRESET 6'h3F

`endif

// >>> vem_host_model.sv
// Serial host model that drives four-wire register frames into the bank.
// Assumes clk_sys as timing reference; every pin change lands on its falling edge.
`default_nettype none

module vem_host_model (
  input wire logic clk_sys,
  input wire logic sdo,
  input wire logic sdoEn,
  output logic csPin_n,
  output logic sclk,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    csPin_n = 1'b1;
    sclk = 1'b1;
    sdi = 1'b0;
  end

  // Half periods of 8 clocks leave margin over the pin filter
  task automatic xfer(input logic rd, input logic [4:0] addr, input logic [7:0] wd,
                      output logic [7:0] rdv);
    logic [15:0] sh;
    sh = {2'b00, rd, addr, wd};
    if (addr == 5'h02) sh[7:6] = 2'b00;
    rdv = 8'h00;
    csPin_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      sdi = sh[i];
      repeat (8) @(negedge clk_sys);
      // Undriven line must not pass for data
      if (i < 8) rdv[i] = sdoEn ? sdo : 1'bz;
      sclk = 1'b1;
      repeat (8) @(negedge clk_sys);
    end
    sdi = ~sdi;
    csPin_n = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask
endmodule // vem_host_model

`default_nettype wire

// >>> vem_id_crc.sv
// Video-ID word builder: 14 payload bits plus a 6-bit CRC.
// Assumes a synchronous active-low reset on clk_sys.
`include "vem_defines.svh"
`default_nettype none

module vem_id_crc (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [13:0] idBits,
  output logic [19:0] idWord
);
  logic [5:0] next_crc;

  // Bit 1 enters first; shift register preset to ones
  always_comb begin
    logic fb;
    fb = 1'b0;
    next_crc = `VEM_CRC_PRESET;
    for (int i = 0; i < 14; i++) begin
      fb = idBits[i] ^ next_crc[5];
      next_crc = {next_crc[4:0], 1'b0} ^ ({6{fb}} & `VEM_CRC_POLY);
    end
  end

  // CRC appended as bits 15..20, CRC MSB first
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      idWord <= 20'h00000;
    end else begin
      idWord <= {next_crc[0], next_crc[1], next_crc[2], next_crc[3], next_crc[4], next_crc[5],
                 idBits};
    end
  end
endmodule // vem_id_crc

`default_nettype wire

// >>> vem_mode_vbi_regs.sv
// Mode and shared VBI payload registers, written over the four-wire serial port.
// Assumes serial pins are asynchronous to clk_sys and SCLK is far slower than clk_sys;
// line23Start is a one-cycle pulse from the line timing on clk_sys.
`include "vem_defines.svh"
`default_nettype none

// Behaviour
// - Mode bit 0: NTSC or PAL
// - Mode bit 1: subcarrier reset
// - Mode bit 4: internal or external timing
// - Colour bars; black burst wins
// - Mode bit 6: black burst enable
// - Shared payload registers, meaning set by mode
// - Register 1 holds ID bits 7..14
// - Register 2 holds ID bits 1..6
// - Device appends 6-bit CRC bits 15..20
// - Widescreen groups mapped over registers 1, 2
// - Register 2 write loads at line 23
// - Payload kept until rewritten
// - CRC X6+X+1, preset all ones
// - Address bit 5 set means read
module vem_mode_vbi_regs (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic csPin_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic line23Start,
  output logic sdo,
  output logic sdoEn,
  output logic standardSelect,
  output logic subcarrierPhaseReset,
  output logic videoIdInsert,
  output logic widescreenInsert,
  output logic internalTimingSelect,
  output logic colourBarOut,
  output logic blackBurstOut,
  output logic converterEnable,
  output logic [19:0] idWord,
  output logic [13:0] widescreenWord,
  output logic widescreenLoad
);
  logic [2:0] syncA, syncB, syncC, filt, prevFilt;
  logic sclkRise, sclkFall, csActive;
  vem_pkg::vem_ser_state_t serState;
  logic [2:0] bitCnt;
  logic [7:0] shiftIn, rdShift, wrData;
  logic [4:0] regAddr, wrAddr;
  logic rdFlag, wrStrobe, widePending;
  logic [7:0] encoderMode, payloadLow;
  logic [5:0] payloadHigh;
  logic [13:0] idBits;
  logic [7:0] byteIn;

  // Pins {cs, sclk, sdi}; stages 2 and 3 must agree before a change counts
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      syncA <= `VEM_PIN_RST;
      syncB <= `VEM_PIN_RST;
      syncC <= `VEM_PIN_RST;
      filt <= `VEM_PIN_RST;
      prevFilt <= `VEM_PIN_RST;
    end else begin
      syncA <= {csPin_n, sclk, sdi};
      syncB <= syncA;
      syncC <= syncB;
      filt <= ((syncB ~^ syncC) & syncB) | ((syncB ^ syncC) & filt);
      prevFilt <= filt;
    end
  end

  assign sclkRise = filt[1] & ~prevFilt[1];
  assign sclkFall = ~filt[1] & prevFilt[1];
  assign csActive = ~filt[2];
  assign byteIn = {shiftIn[6:0], filt[0]};

  function automatic logic [7:0] readMux(input logic [4:0] a, input logic [7:0] m,
                                         input logic [7:0] lo, input logic [5:0] hi);
    case (a)
      `VEM_ADDR_MODE: readMux = m;
      `VEM_ADDR_LOW: readMux = lo;
      `VEM_ADDR_HIGH: readMux = {2'h0, hi};
      default: readMux = 8'h00;
    endcase
  endfunction

  // Serial frame: address byte then data byte, MSB first; one address per select
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      serState <= vem_pkg::VEM_SER_IDLE;
      bitCnt <= 3'h0;
      shiftIn <= 8'h00;
      regAddr <= 5'h00;
      rdFlag <= 1'b0;
    end else if (!csActive) begin
      serState <= vem_pkg::VEM_SER_IDLE;
      bitCnt <= 3'h0;
    end else begin
      case (serState)
        vem_pkg::VEM_SER_IDLE: begin
          serState <= vem_pkg::VEM_SER_ADDR;
          bitCnt <= 3'h0;
        end
        vem_pkg::VEM_SER_ADDR: begin
          if (sclkRise) begin
            shiftIn <= byteIn;
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == `VEM_LAST_BIT) begin
              regAddr <= byteIn[4:0];
              rdFlag <= byteIn[`VEM_ADDR_RD_BIT];
              serState <= vem_pkg::VEM_SER_DATA;
            end
          end
        end
        vem_pkg::VEM_SER_DATA: begin
          if (sclkRise) begin
            shiftIn <= byteIn;
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == `VEM_LAST_BIT) begin
              serState <= vem_pkg::VEM_SER_DONE;
            end
          end
        end
        // Further clocks ignored until select is released
        vem_pkg::VEM_SER_DONE: serState <= vem_pkg::VEM_SER_DONE;
        default: serState <= vem_pkg::VEM_SER_IDLE;
      endcase
    end
  end

  // Write strobe only for write frames
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrStrobe <= 1'b0;
      wrAddr <= 5'h00;
      wrData <= 8'h00;
    end else begin
      wrStrobe <= csActive && serState == vem_pkg::VEM_SER_DATA && sclkRise &&
                  bitCnt == `VEM_LAST_BIT && !rdFlag;
      wrAddr <= regAddr;
      wrData <= byteIn;
    end
  end

  // Read data shifts out on SCLK falling edges
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdShift <= 8'h00;
      sdo <= 1'b0;
      sdoEn <= 1'b0;
    end else begin
      sdoEn <= csActive && serState == vem_pkg::VEM_SER_DATA && rdFlag;
      if (csActive && serState == vem_pkg::VEM_SER_ADDR && sclkRise &&
          bitCnt == `VEM_LAST_BIT) begin
        rdShift <= readMux(byteIn[4:0], encoderMode, payloadLow, payloadHigh);
      end else if (csActive && serState == vem_pkg::VEM_SER_DATA && rdFlag && sclkFall) begin
        sdo <= rdShift[7];
        rdShift <= {rdShift[6:0], 1'b0};
      end
    end
  end

  // Register file; reserved high bits of register 2 are not stored
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      encoderMode <= `VEM_RST_MODE;
      payloadLow <= `VEM_RST_LOW;
      payloadHigh <= `VEM_RST_HIGH;
    end else if (wrStrobe) begin
      case (wrAddr)
        `VEM_ADDR_MODE: encoderMode <= wrData;
        `VEM_ADDR_LOW: payloadLow <= wrData;
        `VEM_ADDR_HIGH: payloadHigh <= wrData[5:0];
        default: encoderMode <= encoderMode;
      endcase
    end
  end

  // Mode decode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      standardSelect <= 1'b0;
      subcarrierPhaseReset <= 1'b0;
      videoIdInsert <= 1'b0;
      widescreenInsert <= 1'b0;
      internalTimingSelect <= 1'b0;
      colourBarOut <= 1'b0;
      blackBurstOut <= 1'b0;
      converterEnable <= 1'b0;
    end else begin
      standardSelect <= encoderMode[`VEM_MODE_STD];
      subcarrierPhaseReset <= encoderMode[`VEM_MODE_SUBRST];
      videoIdInsert <= encoderMode[`VEM_MODE_VID] & ~encoderMode[`VEM_MODE_STD];
      widescreenInsert <= encoderMode[`VEM_MODE_WIDE] & encoderMode[`VEM_MODE_STD];
      internalTimingSelect <= encoderMode[`VEM_MODE_MAS];
      colourBarOut <= encoderMode[`VEM_MODE_BARS] & ~encoderMode[`VEM_MODE_BLACK];
      blackBurstOut <= encoderMode[`VEM_MODE_BLACK];
      converterEnable <= encoderMode[`VEM_MODE_DAC];
    end
  end

  // ID bit k sits at idBits[k-1]
  always_comb begin
    idBits = 14'h0000;
    for (int i = 0; i < 8; i++) begin
      idBits[6 + i] = payloadLow[7 - i];
    end
    for (int i = 0; i < 6; i++) begin
      idBits[i] = payloadHigh[5 - i];
    end
  end

  vem_id_crc vem_id_crc_i (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .idBits(idBits),
    .idWord(idWord)
  );

  // Register 2 write arms the update; a write racing line 23 waits a frame
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      widePending <= 1'b0;
      widescreenWord <= 14'h0000;
      widescreenLoad <= 1'b0;
    end else begin
      widePending <= (wrStrobe && wrAddr == `VEM_ADDR_HIGH) ||
                     (widePending && !line23Start);
      widescreenLoad <= widePending && line23Start;
      if (widePending && line23Start) begin
        widescreenWord <= {payloadHigh, payloadLow};
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_std;
    wrStrobe && wrAddr == `VEM_ADDR_MODE |-> ##2 standardSelect == $past(wrData[0], 2);
  endproperty
  a_std: assert property (p_std) else $error("standard select mismatch");
  property p_subrst;
    wrStrobe && wrAddr == `VEM_ADDR_MODE |-> ##2 subcarrierPhaseReset == $past(wrData[1], 2);
  endproperty
  a_subrst: assert property (p_subrst) else $error("subcarrier reset mismatch");
  property p_mas;
    wrStrobe && wrAddr == `VEM_ADDR_MODE |-> ##2 internalTimingSelect == $past(wrData[4], 2);
  endproperty
  a_mas: assert property (p_mas) else $error("timing select mismatch");
  property p_prio;
    wrStrobe && wrAddr == `VEM_ADDR_MODE |-> ##2 colourBarOut == ($past(wrData[6:5], 2) == 2'h1);
  endproperty
  a_prio: assert property (p_prio) else $error("colour bar output mismatch");
  property p_black;
    wrStrobe && wrAddr == `VEM_ADDR_MODE && wrData[6] |-> ##2 blackBurstOut && !colourBarOut;
  endproperty
  a_black: assert property (p_black) else $error("black burst not enabled");
  property p_dac;
    wrStrobe && wrAddr == `VEM_ADDR_MODE |-> ##2 converterEnable == $past(wrData[7], 2);
  endproperty
  a_dac: assert property (p_dac) else $error("converter enable mismatch");
  property p_idlow;
    ##1 1'b1 |-> idWord[13] == $past(payloadLow[0]) && idWord[6] == $past(payloadLow[7]);
  endproperty
  a_idlow: assert property (p_idlow) else $error("ID bits 7..14 misplaced");
  property p_idhigh;
    ##1 1'b1 |-> idWord[5] == $past(payloadHigh[0]) && idWord[0] == $past(payloadHigh[5]);
  endproperty
  a_idhigh: assert property (p_idhigh) else $error("ID bits 1..6 misplaced");
  property p_arm;
    wrStrobe && wrAddr == `VEM_ADDR_HIGH |=> widePending;
  endproperty
  a_arm: assert property (p_arm) else $error("register 2 write did not arm update");
  property p_load;
    widePending && line23Start |=> widescreenLoad &&
      widescreenWord == {$past(payloadHigh), $past(payloadLow)};
  endproperty
  a_load: assert property (p_load) else $error("widescreen word not loaded at line 23");
  property p_hold;
    !$stable(widescreenWord) |-> widescreenLoad;
  endproperty
  a_hold: assert property (p_hold) else $error("widescreen word changed without update");
  property p_rdnowr;
    sdoEn |-> !wrStrobe;
  endproperty
  a_rdnowr: assert property (p_rdnowr) else $error("write during read frame");
  c_write: cover property (wrStrobe && wrAddr == `VEM_ADDR_MODE);
  c_read: cover property (sdoEn && sclkFall);
  c_wide: cover property (widescreenLoad);
  c_race: cover property (wrStrobe && wrAddr == `VEM_ADDR_HIGH && widePending && line23Start);
endmodule // vem_mode_vbi_regs

`default_nettype wire

// >>> vem_mode_vbi_regs_tb.sv
// Self-checking bench for the mode and VBI payload register bank.
// Assumes the host model drives the serial pins; bench drives reset and line timing.
`default_nettype none

module vem_mode_vbi_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys, rst_n, line23Start, csPin_n, sclk, sdi, sdo, sdoEn, widescreenLoad;
  logic standardSelect, subcarrierPhaseReset, videoIdInsert, widescreenInsert;
  logic internalTimingSelect, colourBarOut, blackBurstOut, converterEnable;
  logic [19:0] idWord, expId;
  logic [13:0] widescreenWord;
  logic [7:0] modeOut, rdv;
  logic [5:0] crc;
  logic [15:0] pairs [2] = '{16'hA52C, 16'hFF3F};
  logic [15:0] rows [13] = '{16'h0000, 16'h0101, 16'h0202, 16'h0404, 16'h0501, 16'h0800,
    16'h0909, 16'h1010, 16'h2020, 16'h6040, 16'h4040, 16'h8080, 16'hFFDB};
  int err_count, compares, hits;

  assign modeOut = {converterEnable, blackBurstOut, colourBarOut, internalTimingSelect,
    widescreenInsert, videoIdInsert, subcarrierPhaseReset, standardSelect};

  vem_mode_vbi_regs vem_mode_vbi_regs_i (.clk_sys(clk_sys), .rst_n(rst_n), .csPin_n(csPin_n),
    .sclk(sclk), .sdi(sdi), .line23Start(line23Start), .sdo(sdo), .sdoEn(sdoEn),
    .standardSelect(standardSelect), .subcarrierPhaseReset(subcarrierPhaseReset),
    .videoIdInsert(videoIdInsert), .widescreenInsert(widescreenInsert),
    .internalTimingSelect(internalTimingSelect), .colourBarOut(colourBarOut),
    .blackBurstOut(blackBurstOut), .converterEnable(converterEnable), .idWord(idWord),
    .widescreenWord(widescreenWord), .widescreenLoad(widescreenLoad));

  vem_host_model vem_host_model_i (.clk_sys(clk_sys), .sdo(sdo), .sdoEn(sdoEn),
    .csPin_n(csPin_n), .sclk(sclk), .sdi(sdi));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    vem_host_model_i.xfer(1'b0, a, d, rdv);
  endtask

  task automatic rd(input logic [4:0] a);
    vem_host_model_i.xfer(1'b1, a, 8'h00, rdv);
  endtask

  // Load window is bounded; a one-cycle pulse counts once
  task automatic pulse();
    hits = 0;
    line23Start = 1'b1;
    @(negedge clk_sys);
    line23Start = 1'b0;
    repeat (6) begin
      if (widescreenLoad === 1'b1) hits++;
      @(negedge clk_sys);
    end
  endtask

  initial begin
    rst_n = 1'b0;
    line23Start = 1'b0;
    err_count = 0;
    compares = 0;
    repeat (16) @(negedge clk_sys);
    check("reset outputs", 20'({modeOut, widescreenLoad, sdoEn}), 20'h00000);
    check("reset id word", idWord, 20'h00000);
    check("reset wide word", 20'(widescreenWord), 20'h00000);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    for (int a = 0; a < 4; a++) begin
      rd(a[4:0]);
      check("reset read", 20'(rdv), 20'h00000);
    end
    foreach (rows[i]) begin
      wr(5'h00, rows[i][15:8]);
      rd(5'h00);
      check("mode readback", 20'(rdv), 20'(rows[i][15:8]));
      check("mode outputs", 20'(modeOut), 20'(rows[i][7:0]));
    end
    wr(5'h05, 8'hFF);
    rd(5'h05);
    check("unmapped read", 20'(rdv), 20'h00000);
    wr(5'h00, 8'h04);
    foreach (pairs[p]) begin
      wr(5'h01, pairs[p][15:8]);
      wr(5'h02, pairs[p][7:0]);
      for (int k = 1; k <= 6; k++) expId[k-1] = pairs[p][6-k];
      for (int k = 7; k <= 14; k++) expId[k-1] = pairs[p][22-k];
      crc = 6'h3F;
      for (int j = 0; j < 14; j++) begin
        crc = {crc[4:0], 1'b0} ^ ((expId[j] ^ crc[5]) ? 6'h03 : 6'h00);
      end
      for (int j = 0; j < 6; j++) expId[14+j] = crc[5-j];
      check("id word", idWord, expId);
      rd(5'h02);
      check("high readback", 20'(rdv), 20'(pairs[p][7:0]));
    end
    wr(5'h00, 8'h09);
    check("id word kept", idWord, expId);
    wr(5'h01, 8'h3C);
    wr(5'h02, 8'h15);
    check("wide before line", 20'(widescreenWord), 20'h00000);
    pulse();
    check("wide load count", 20'(hits), 20'h00001);
    check("wide word", 20'(widescreenWord), 20'h0153C);
    pulse();
    check("wide reload count", 20'(hits), 20'h00000);
    check("wide word kept", 20'(widescreenWord), 20'h0153C);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("mid reset mode", 20'(modeOut), 20'h00000);
    check("mid reset wide word", 20'(widescreenWord), 20'h00000);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    rd(5'h00);
    check("mode after reset", 20'(rdv), 20'h00000);
    results();
  end
endmodule // vem_mode_vbi_regs_tb

`default_nettype wire

// >>> vem_pkg.sv
// Types shared by the mode/VBI register bank.
// Assumes vem_defines.svh is visible on the include path.
`default_nettype none

package vem_pkg;
  typedef enum logic [1:0] {
    VEM_SER_IDLE = 2'b00,
    VEM_SER_ADDR = 2'b01,
    VEM_SER_DATA = 2'b10,
    VEM_SER_DONE = 2'b11
  } vem_ser_state_t;
endpackage

`default_nettype wire
